// file: design/lsir_streak.sv
// consecutive condition counter with saturation at the needed count
`timescale 1ns/1ps
module lsir_streak #(
    parameter int WIDTH = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic step,
    input wire logic cond,
    input wire logic [WIDTH-1:0] need,
    output logic hit
);
    logic [WIDTH-1:0] cnt_r;
    logic [WIDTH-1:0] cnt_nxt;

    initial begin
        if (WIDTH < 4) $error("lsir_streak: WIDTH must hold a count of 8");
    end

    // restart on a miss, saturate once the streak is long enough
    always_comb begin
        cnt_nxt = cnt_r;
        if (step) begin
            if (!cond) cnt_nxt = '0;
            else if (cnt_r < need) cnt_nxt = WIDTH'(cnt_r + 1'b1);
        end
    end

    assign hit = step && cond && (cnt_nxt >= need);

    always_ff @(posedge clk) begin
        if (rst) cnt_r <= '0;
        else cnt_r <= cnt_nxt;
    end
endmodule

// file: design/lsir_sync.sv
// two flip-flop synchroniser for one level
`timescale 1ns/1ps
module lsir_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic d,
    output logic q
);
    logic meta_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            // reset to the idle level of the pin so no false edge follows
            meta_r <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

// file: design/lsir_top.sv
// interrupt and flag reporting of an ambient light sensor
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module lsir_top #(
    parameter int CNT_WIDTH = 4
) (
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic [3:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA,
    input wire logic CONV_DONE,
    input wire logic [15:0] CONV_RESULT,
    input wire logic LINK_CLK,
    input wire logic LINK_ARA,
    output logic ALERT_ANSWER,
    output logic INT_OUT,
    output logic INT_OE,
    output logic FLAG_HIGH,
    output logic FLAG_LOW,
    output logic CONV_READY
);
    // ---------------------------------------------
    // declarations
    // ---------------------------------------------
    logic [1:0] fc_r;
    logic sense_r;
    logic latch_r;
    logic [1:0] mode_r;
    logic [15:0] low_r;
    logic [15:0] high_r;
    logic [15:0] result_r;
    logic rdy_r;
    logic fh_r;
    logic fl_r;
    logic int_r;
    logic rdy_nxt;
    logic fh_nxt;
    logic fl_nxt;
    logic int_nxt;
    logic sense_nxt;
    logic cfg_rd;
    logic cfg_wr;
    logic wr_run;
    logic latch_clear;
    logic eoc;
    logic hi_hit;
    logic lo_hit;
    logic [CNT_WIDTH-1:0] need;
    logic lclk_s;
    logic ara_s;
    logic lclk_d_r;
    logic ara_smp_r;
    logic lclk_rise;
    logic ara_evt;
    logic [15:0] rd_nxt;

    initial begin
        if (CNT_WIDTH < 4) $error("lsir_top: CNT_WIDTH must hold 8");
    end

    // ---------------------------------------------
    // decode
    // ---------------------------------------------
    assign cfg_rd = RD && (ADDR == lsir_pkg::ADDR_CONFIG);
    assign cfg_wr = WR && (ADDR == lsir_pkg::ADDR_CONFIG);
    assign wr_run = cfg_wr && (WDATA[lsir_pkg::CFG_MODE_LSB +: 2]
        != lsir_pkg::MODE_SHUTDOWN);
    assign latch_clear = cfg_wr && latch_r && !WDATA[lsir_pkg::CFG_LATCH];
    assign eoc = (low_r[lsir_pkg::LOW_EXP_LSB +: 2]
        == lsir_pkg::EOC_CODE);
    assign need = CNT_WIDTH'(4'h1 << fc_r);
    assign sense_nxt = cfg_wr ? WDATA[lsir_pkg::CFG_SENSE] : sense_r;

    // ---------------------------------------------
    // alert response seen on the link clock
    // ---------------------------------------------
    lsir_sync #(.RST_VAL(1'b1)) u_sync_clk (
        .clk(CLOCK),
        .rst(RESET),
        .d(LINK_CLK),
        .q(lclk_s)
    );

    lsir_sync u_sync_ara (
        .clk(CLOCK),
        .rst(RESET),
        .d(LINK_ARA),
        .q(ara_s)
    );

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            // link clock idles high
            lclk_d_r <= 1'b1;
            ara_smp_r <= 1'b0;
        end else begin
            lclk_d_r <= lclk_s;
            if (lclk_rise) ara_smp_r <= ara_s;
        end
    end

    assign lclk_rise = lclk_s && !lclk_d_r;
    assign ara_evt = lclk_rise && ara_s && !ara_smp_r;

    // ---------------------------------------------
    // consecutive fault streaks
    // ---------------------------------------------
    lsir_streak #(.WIDTH(CNT_WIDTH)) u_streak_hi (
        .clk(CLOCK),
        .rst(RESET),
        .step(CONV_DONE),
        .cond(CONV_RESULT > high_r),
        .need(need),
        .hit(hi_hit)
    );

    lsir_streak #(.WIDTH(CNT_WIDTH)) u_streak_lo (
        .clk(CLOCK),
        .rst(RESET),
        .step(CONV_DONE),
        .cond(CONV_RESULT < low_r),
        .need(need),
        .hit(lo_hit)
    );

    // ---------------------------------------------
    // software registers
    // ---------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            fc_r <= lsir_pkg::FC_RST;
            sense_r <= lsir_pkg::SENSE_RST;
            latch_r <= lsir_pkg::LATCH_RST;
            mode_r <= lsir_pkg::MODE_RST;
        end else if (cfg_wr) begin
            fc_r <= WDATA[lsir_pkg::CFG_FC_LSB +: 2];
            sense_r <= WDATA[lsir_pkg::CFG_SENSE];
            latch_r <= WDATA[lsir_pkg::CFG_LATCH];
            mode_r <= WDATA[lsir_pkg::CFG_MODE_LSB +: 2];
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            low_r <= lsir_pkg::LOW_RST;
            high_r <= lsir_pkg::HIGH_RST;
        end else if (WR && ADDR == lsir_pkg::ADDR_LOW) begin
            low_r <= WDATA;
        end else if (WR && ADDR == lsir_pkg::ADDR_HIGH) begin
            high_r <= WDATA;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) result_r <= lsir_pkg::DATA_ZERO;
        else if (CONV_DONE) result_r <= CONV_RESULT;
    end

    // ---------------------------------------------
    // flag and interrupt update; sets win over clears, except that with latch 0 a low streak overrides a high streak
    // ---------------------------------------------
    always_comb begin
        rdy_nxt = rdy_r;
        fh_nxt = fh_r;
        fl_nxt = fl_r;
        int_nxt = int_r;
        if (cfg_rd || wr_run) rdy_nxt = 1'b0;
        if (latch_r && cfg_rd) begin
            fh_nxt = 1'b0;
            fl_nxt = 1'b0;
            int_nxt = 1'b0;
        end
        if (latch_r && ara_evt) int_nxt = 1'b0;
        if (eoc && (cfg_rd || wr_run)) int_nxt = 1'b0;
        if (latch_clear) int_nxt = 1'b0;
        if (CONV_DONE) begin
            rdy_nxt = 1'b1;
            if (eoc) int_nxt = 1'b1;
            if (hi_hit) begin
                fh_nxt = 1'b1;
                if (!latch_r) fl_nxt = 1'b0;
                if (!eoc) int_nxt = 1'b1;
            end
            if (lo_hit) begin
                fl_nxt = 1'b1;
                if (!latch_r) fh_nxt = 1'b0;
                if (!eoc) int_nxt = latch_r;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            rdy_r <= 1'b0;
            fh_r <= 1'b0;
            fl_r <= 1'b0;
            int_r <= 1'b0;
        end else begin
            rdy_r <= rdy_nxt;
            fh_r <= fh_nxt;
            fl_r <= fl_nxt;
            int_r <= int_nxt;
        end
    end

    // ---------------------------------------------
    // pins: open drain, enable pulls the line low
    // ---------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            // interrupt inactive after reset: enable equals sense select
            INT_OE <= lsir_pkg::SENSE_RST;
            INT_OUT <= 1'b0;
            ALERT_ANSWER <= 1'b0;
        end else begin
            INT_OE <= (int_nxt != sense_nxt);
            INT_OUT <= 1'b0;
            ALERT_ANSWER <= ara_evt && latch_r && int_r;
        end
    end

    assign FLAG_HIGH = fh_r;
    assign FLAG_LOW = fl_r;
    assign CONV_READY = rdy_r;

    // ---------------------------------------------
    // read port
    // ---------------------------------------------
    always_comb begin
        rd_nxt = lsir_pkg::DATA_ZERO;
        case (ADDR)
            lsir_pkg::ADDR_RESULT: rd_nxt = result_r;
            lsir_pkg::ADDR_CONFIG: begin
                rd_nxt[lsir_pkg::CFG_FC_LSB +: 2] = fc_r;
                rd_nxt[lsir_pkg::CFG_SENSE] = sense_r;
                rd_nxt[lsir_pkg::CFG_LATCH] = latch_r;
                rd_nxt[lsir_pkg::CFG_MODE_LSB +: 2] = mode_r;
                rd_nxt[lsir_pkg::CFG_RDY] = rdy_r;
                rd_nxt[lsir_pkg::CFG_FH] = fh_r;
                rd_nxt[lsir_pkg::CFG_FL] = fl_r;
            end
            lsir_pkg::ADDR_LOW: rd_nxt = low_r;
            lsir_pkg::ADDR_HIGH: rd_nxt = high_r;
            default: rd_nxt = lsir_pkg::DATA_ZERO;
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) RDATA <= lsir_pkg::DATA_ZERO;
        else if (RD) RDATA <= rd_nxt;
    end

    // ---------------------------------------------
    // assertions
    // ---------------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);

    a_hys_high_set: assert property (
        !latch_r && !eoc && CONV_DONE && hi_hit && !lo_hit
        |=> int_r && fh_r && !fl_r && INT_OE == !sense_r)
        else $error("high streak did not raise interrupt");

    a_hys_low_set: assert property (
        !latch_r && !eoc && CONV_DONE && lo_hit && !hi_hit
        |=> !int_r && fl_r && !fh_r)
        else $error("low streak did not drop interrupt");

    a_hys_cfg_keep: assert property (
        !latch_r && !eoc && !CONV_DONE && (cfg_rd || cfg_wr)
        |=> $stable(int_r) && $stable(fh_r) && $stable(fl_r))
        else $error("config access moved transparent outputs");

    a_ara_ignored: assert property (
        !latch_r && ara_evt && !CONV_DONE && !cfg_rd && !cfg_wr
        |=> !ALERT_ANSWER && $stable(int_r))
        else $error("alert response answered with latch 0");

    a_ready_set: assert property (
        CONV_DONE |=> rdy_r ##1 (rdy_r || $past(cfg_rd || wr_run)))
        else $error("completion did not set ready");

    a_read_clr_rdy: assert property (
        rdy_r && cfg_rd && !CONV_DONE |=> !rdy_r)
        else $error("config read left ready set");

    a_shutdown_keep: assert property (
        cfg_wr && !wr_run && !CONV_DONE && !cfg_rd && !ara_evt
        && !latch_clear
        |=> $stable(rdy_r) && $stable(int_r) && $stable(fh_r))
        else $error("shutdown write changed state");

    a_pin_sense: assert property (
        INT_OE == (int_r != sense_r))
        else $error("pin level does not follow sense select");

    a_eoc_active: assert property (
        eoc && CONV_DONE |=> int_r)
        else $error("end of conversion did not assert interrupt");

    a_eoc_rd_clear: assert property (
        eoc && cfg_rd && !CONV_DONE ##1 !CONV_DONE |-> !int_r)
        else $error("read did not clear end of conversion interrupt");

    a_latch_rd_flags: assert property (
        latch_r && cfg_rd && !CONV_DONE |=> !fh_r && !fl_r && !int_r)
        else $error("latched read did not clear flags");

    a_alert_clear: assert property (
        latch_r && ara_evt && !CONV_DONE && !cfg_rd
        |=> !int_r && $stable(fh_r) && $stable(fl_r))
        else $error("alert response left latched interrupt active");

    a_eoc_run_clear: assert property (
        eoc && wr_run && !CONV_DONE |=> !int_r)
        else $error("run write kept eoc interrupt");

    a_eoc_latch_keep: assert property (
        eoc && latch_r && hi_hit && !cfg_rd |=> fh_r && fl_r == $past(fl_r))
        else $error("high fault disturbed low flag in latched eoc");

    c_hys_high: cover property (!latch_r && hi_hit ##1 int_r);
    c_eoc_cycle: cover property (eoc && CONV_DONE ##[1:20] cfg_rd);
    c_alert: cover property (ALERT_ANSWER);
    c_latched_low: cover property (latch_r && lo_hit ##1 fl_r);
    c_latch_clear: cover property (latch_clear && int_r);
endmodule

// file: inc/lsir_pkg.sv
// constants for the light sensor interrupt reporting block
package lsir_pkg;
    // ---------------------------------------------
    // register offsets
    // ---------------------------------------------
    localparam logic [3:0] ADDR_RESULT = 4'h0;
    localparam logic [3:0] ADDR_CONFIG = 4'h1;
    localparam logic [3:0] ADDR_LOW = 4'h2;
    localparam logic [3:0] ADDR_HIGH = 4'h3;
    // ---------------------------------------------
    // configuration field positions
    // ---------------------------------------------
    localparam int CFG_FC_LSB = 0;
    localparam int CFG_SENSE = 2;
    localparam int CFG_LATCH = 4;
    localparam int CFG_MODE_LSB = 5;
    localparam int CFG_RDY = 7;
    localparam int CFG_FH = 8;
    localparam int CFG_FL = 9;
    localparam int LOW_EXP_LSB = 14;
    // ---------------------------------------------
    // encodings and values after reset
    // ---------------------------------------------
    localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
    localparam logic [1:0] EOC_CODE = 2'h3;
    localparam logic [1:0] FC_RST = 2'h0;
    localparam logic SENSE_RST = 1'h0;
    localparam logic LATCH_RST = 1'h1;
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic [15:0] LOW_RST = 16'h0000;
    localparam logic [15:0] HIGH_RST = 16'hBFFF;
    localparam logic [15:0] DATA_ZERO = 16'h0000;
endpackage

// file: verification/lsir_host.sv
// host side of the serial link: link clock and alert response level
`timescale 1ns/1ps
module lsir_host (
    output logic link_clk,
    output logic link_ara
);
    // ---------------------------------------------
    // idle bus: clock parked high, no alert response
    // ---------------------------------------------
    initial begin
        link_clk = 1'b1;
        link_ara = 1'b0;
    end
    // ---------------------------------------------
    // one link clock period of 200 ns
    // ---------------------------------------------
    task automatic link_rise();
        #100 link_clk = 1'b0;
        #100 link_clk = 1'b1;
    endtask
    // low seen at one rise, high at the next two, low again at the last
    // the level only moves while the link clock is low
    task automatic alert();
        link_rise();
        #100 link_clk = 1'b0;
        link_ara = 1'b1;
        #100 link_clk = 1'b1;
        link_rise();
        #100 link_clk = 1'b0;
        link_ara = 1'b0;
        #100 link_clk = 1'b1;
    endtask
endmodule

// file: verification/tb_lsir_top.sv
// self-checking bench for the interrupt and flag reporting block
`timescale 1ns/1ps
module tb_lsir_top;
    // ---------------------------------------------
    // stimulus, outputs and expected state
    // ---------------------------------------------
    logic CLOCK, RESET, WR, RD, CONV_DONE, LINK_CLK, LINK_ARA;
    logic [3:0] ADDR;
    logic [15:0] WDATA, CONV_RESULT, RDATA;
    logic ALERT_ANSWER, INT_OUT, INT_OE, FLAG_HIGH, FLAG_LOW, CONV_READY;
    int fail_count, check_count, answers, m_answers, hcnt, lcnt, n;
    integer seed;
    logic [1:0] m_fc, m_mode;
    logic m_sense, m_latch, m_int, m_fh, m_fl, m_rdy;
    logic [15:0] m_low, m_high, m_res;
    lsir_top u_lsir_top (.CLOCK(CLOCK), .RESET(RESET), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
        .CONV_DONE(CONV_DONE), .CONV_RESULT(CONV_RESULT),
        .LINK_CLK(LINK_CLK), .LINK_ARA(LINK_ARA),
        .ALERT_ANSWER(ALERT_ANSWER), .INT_OUT(INT_OUT), .INT_OE(INT_OE),
        .FLAG_HIGH(FLAG_HIGH), .FLAG_LOW(FLAG_LOW),
        .CONV_READY(CONV_READY));
    lsir_host u_lsir_host (.link_clk(LINK_CLK), .link_ara(LINK_ARA));
    initial begin
        CLOCK = 1'b0;
        forever #12.5 CLOCK = ~CLOCK;
    end
    always @(posedge CLOCK) begin
        if (ALERT_ANSWER === 1'b1) answers <= answers + 1;
    end
    // ---------------------------------------------
    // expectation helpers and compares
    // ---------------------------------------------
    function automatic logic eoc();
        return m_low[15:14] == 2'h3;
    endfunction
    function automatic logic [15:0] cfg_word();
        return {6'h00, m_fl, m_fh, m_rdy, m_mode, m_latch, 1'b0, m_sense,
            m_fc};
    endfunction
    task automatic chk1(input string name, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %b seen %b", name, e, g);
        end
    endtask
    task automatic chk16(input string name, input logic [15:0] e,
        input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", name, e, g);
        end
    endtask
    task automatic chk_all();
        chk1("flag high", m_fh, FLAG_HIGH);
        chk1("flag low", m_fl, FLAG_LOW);
        chk1("ready", m_rdy, CONV_READY);
        chk1("pin enable", m_int ^ m_sense, INT_OE);
        chk1("pin data", 1'b0, INT_OUT);
    endtask
    // ---------------------------------------------
    // bus, conversion and alert drivers
    // ---------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge CLOCK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLOCK);
        WR <= 1'b0;
        #1;
        if (a == lsir_pkg::ADDR_CONFIG) begin
            if (m_latch && !d[4]) m_int = 1'b0;
            if (d[6:5] != 2'h0) begin
                m_rdy = 1'b0;
                if (eoc()) m_int = 1'b0;
            end
            {m_mode, m_latch, m_sense, m_fc} = {d[6:4], d[2:0]};
        end
        if (a == lsir_pkg::ADDR_LOW) m_low = d;
        if (a == lsir_pkg::ADDR_HIGH) m_high = d;
        chk_all();
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge CLOCK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge CLOCK);
        RD <= 1'b0;
        #1;
        chk16("read data", e, RDATA);
        if (a == lsir_pkg::ADDR_CONFIG) begin
            m_rdy = 1'b0;
            if (m_latch || eoc()) m_int = 1'b0;
            if (m_latch) {m_fh, m_fl} = 2'h0;
        end
        chk_all();
    endtask
    task automatic conv(input logic [15:0] r);
        @(posedge CLOCK);
        CONV_DONE <= 1'b1;
        CONV_RESULT <= r;
        @(posedge CLOCK);
        CONV_DONE <= 1'b0;
        #1;
        hcnt = (r > m_high) ? hcnt + 1 : 0;
        lcnt = (r < m_low) ? lcnt + 1 : 0;
        if (eoc()) m_int = 1'b1;
        if (hcnt >= (1 << m_fc)) begin
            {m_fh, m_int} = 2'h3;
            if (!m_latch) m_fl = 1'b0;
        end
        if (lcnt >= (1 << m_fc)) begin
            m_fl = 1'b1;
            if (!m_latch) m_fh = 1'b0;
            m_int = m_latch || eoc();
        end
        m_rdy = 1'b1;
        m_res = r;
        chk_all();
    endtask
    task automatic alert();
        #37;
        u_lsir_host.alert();
        repeat (10) @(posedge CLOCK);
        #1;
        if (m_latch && m_int) m_answers++;
        if (m_latch) m_int = 1'b0;
        chk16("answers", 16'(m_answers), 16'(answers));
        chk_all();
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ---------------------------------------------
    // main sequence and watchdog
    // ---------------------------------------------
    initial begin
        #(25 * 60000);
        fail_count++;
        results();
    end
    initial begin
        seed = 32'h101002c0;
        {RESET, WR, RD, CONV_DONE, ADDR, WDATA, CONV_RESULT} = 'h0;
        RESET = 1'b1;
        {fail_count, check_count, answers, m_answers, hcnt, lcnt} = 'h0;
        {m_fc, m_mode, m_sense, m_int, m_fh, m_fl, m_rdy} = 'h0;
        {m_latch, m_low, m_high, m_res} = {1'b1, 16'h0000, 16'hBFFF, 16'h0};
        repeat (3) @(posedge CLOCK);
        RESET <= 1'b0;
        rd(lsir_pkg::ADDR_CONFIG, 16'h0010);
        rd(lsir_pkg::ADDR_LOW, 16'h0000);
        rd(lsir_pkg::ADDR_HIGH, 16'hBFFF);
        wr(4'h4, 16'hFFFF);
        rd(4'h4, 16'h0000);
        for (int e = 1; e >= 0; e--) begin
            for (int k = 0; k < 16; k++) begin
                n = 1 << k[1:0];
                conv(16'hF000);
                wr(lsir_pkg::ADDR_LOW, e ? 16'hC000 : 16'h4000);
                wr(lsir_pkg::ADDR_HIGH, 16'hE000);
                wr(lsir_pkg::ADDR_CONFIG, {9'h0, 2'h2, k[3], 1'b0, k[2],
                    k[1:0]});
                conv(16'hD000);
                repeat (n - 1) conv(16'hF000);
                conv(16'hD000);
                repeat (n) conv(16'hF000);
                repeat (n) conv(16'h0100);
                repeat (12) conv(16'($random(seed)));
                alert();
                rd(lsir_pkg::ADDR_RESULT, m_res);
                rd(lsir_pkg::ADDR_CONFIG, cfg_word());
                rd(lsir_pkg::ADDR_CONFIG, cfg_word());
                conv(16'hF000);
                wr(lsir_pkg::ADDR_CONFIG, {9'h0, 2'h0, k[3], 1'b0, k[2],
                    k[1:0]});
                rd(lsir_pkg::ADDR_CONFIG, cfg_word());
            end
        end
        results();
    end
endmodule
